// ==== hdl/gsl_pkg.sv ====
// Constants, types and pattern helpers for the gateway status lamp controller
package gsl_pkg;
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned MS_NS = 1000000;
    localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned SHORT_MS = 200;
    localparam int unsigned LONG_MS = 1000;
    localparam int unsigned FAST_HALF_MS = 250;
    localparam int unsigned SLOW_HALF_MS = 500;
    localparam int unsigned WARN_SYS_MS = 60000;
    localparam int unsigned ACT_WINDOW_MS = 500;
    localparam logic [15:0] WARN_HOLD_RST = 16'(WARN_SYS_MS);
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HOLD = 8'h04;
    localparam logic [7:0] OFS_SEL = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam int CTRL_ST_EN = 0;
    localparam int CTRL_ST_LSB = 1;
    localparam int CTRL_CODE_EN = 4;
    localparam int CTRL_CODE_LSB = 5;
    localparam int CMD_RAISE = 8;
    localparam int CMD_PROTO = 9;
    localparam int AL_CHG_BIT = 4;
    localparam logic [7:0] SEL_TEST = 8'hee;
    localparam logic [7:0] SEL_CFG = 8'hff;
    localparam logic [7:0] SEL_RSVD = 8'hdd;
    localparam logic [3:0] SERIOUS_MAX = 4'h4;
    localparam int LMP_FAULT = 0;
    localparam int LMP_RUN = 1;
    localparam int LMP_STATE = 2;
    localparam int LMP_CODE = 3;
    typedef enum logic [2:0] {PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE,
        PAT_FAST, PAT_SLOW} gsl_pat_t;
    typedef enum logic [1:0] {FB_INIT, FB_PREOP, FB_SAFEOP, FB_OP} gsl_fb_t;
    typedef enum logic [2:0] {LOOK_OFF, LOOK_GREEN, LOOK_GREEN_FLASH, LOOK_ALT,
        LOOK_RED, LOOK_RED_FLASH} gsl_look_t;
    typedef enum logic [1:0] {MODE_RUN, MODE_TEST, MODE_CFG} gsl_mode_t;
    typedef struct packed {
        gsl_fb_t fb_state;
        logic config_error;
        logic watchdog_timeout;
        logic [15:0] app_layer_state_word;
    } gsl_fb_status_t;
    typedef struct packed {
        logic valid;
        logic proto;
        logic [3:0] code;
    } gsl_err_t;
    typedef struct packed {
        logic fault_lamp;
        logic run_lamp;
        logic state_green;
        logic state_red;
        logic code_lamp_weight_eight;
        logic code_lamp_weight_four;
        logic code_lamp_weight_two;
        logic code_lamp_weight_one;
    } gsl_lamps_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gsl_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } gsl_apb_rsp_t;

    function automatic logic [10:0] pat_period(input gsl_pat_t p);
        case (p)
            PAT_BLINK: pat_period = 11'(2 * SHORT_MS);
            PAT_SINGLE: pat_period = 11'(SHORT_MS + LONG_MS);
            PAT_DOUBLE: pat_period = 11'(3 * SHORT_MS + LONG_MS);
            PAT_FAST: pat_period = 11'(2 * FAST_HALF_MS);
            PAT_SLOW: pat_period = 11'(2 * SLOW_HALF_MS);
            default: pat_period = 11'h001;
        endcase
    endfunction : pat_period

    function automatic logic pat_lit(input gsl_pat_t p, input logic [10:0] pos);
        case (p)
            PAT_ON: pat_lit = 1'b1;
            PAT_BLINK, PAT_SINGLE: pat_lit = pos < 11'(SHORT_MS);
            PAT_DOUBLE: pat_lit = (pos < 11'(SHORT_MS))
                || (pos >= 11'(2 * SHORT_MS) && pos < 11'(3 * SHORT_MS));
            PAT_FAST: pat_lit = pos < 11'(FAST_HALF_MS);
            PAT_SLOW: pat_lit = pos < 11'(SLOW_HALF_MS);
            default: pat_lit = 1'b0;
        endcase
    endfunction : pat_lit
endpackage : gsl_pkg

// ==== hdl/gsl_lamp_ctrl.sv ====
// Status lamp controller with APB register slave and rotary selector capture
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module gsl_lamp_ctrl #(
    parameter int unsigned MS_CYCLES_P = gsl_pkg::MS_CYCLES
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input gsl_pkg::gsl_apb_req_t apb_in,
    output gsl_pkg::gsl_apb_rsp_t apb_out,
    input gsl_pkg::gsl_fb_status_t fb_status_in,
    input wire logic serial_exchange_in,
    input gsl_pkg::gsl_err_t err_in,
    input wire logic [3:0] id_high_selector_in,
    input wire logic [3:0] id_low_selector_in,
    output gsl_pkg::gsl_lamps_t lamps_out
);
    import gsl_pkg::*;

    logic [17:0] tick_cnt_r;
    logic tick_r;
    gsl_pat_t pat_nxt [4];
    gsl_pat_t pat_r [4];
    logic [10:0] pos_r [4];
    logic lit [4];
    gsl_look_t look_nxt;
    gsl_look_t look_r;
    logic [3:0] code_val_nxt;
    logic [3:0] code_val_r;
    logic [7:0] sel_meta_r;
    logic [7:0] sel_sync_r;
    logic [7:0] rotary_selector_value;
    logic [1:0] cap_wait_r;
    gsl_mode_t mode_r;
    logic st_ovr_en_r;
    gsl_look_t st_ovr_r;
    logic code_ovr_en_r;
    logic [3:0] code_ovr_r;
    logic [15:0] hold_r;
    logic ser_r;
    logic [3:0] ser_code_r;
    logic [3:0] warn_code_r;
    logic warn_proto_r;
    logic [15:0] warn_left_r;
    logic seen_r;
    logic [9:0] act_left_r;
    gsl_err_t src;
    logic new_ser;
    logic new_warn;
    logic show_on;
    logic [3:0] show_code;
    logic show_proto;
    logic acc;
    logic done;
    logic cmd_wr;
    logic mapped;
    logic [31:0] rd_data;
    gsl_apb_rsp_t rsp_r;
    gsl_lamps_t lamps_r;

    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    // Millisecond tick for all pattern and hold timing
    always_ff @(posedge clock_in)
    begin
        if (reset_in || tick_cnt_r == 18'(MS_CYCLES_P - 1))
            tick_cnt_r <= 18'h00000;
        else
            tick_cnt_r <= tick_cnt_r + 18'h00001;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            tick_r <= 1'b0;
        else
            tick_r <= tick_cnt_r == 18'(MS_CYCLES_P - 1);
    end

    chk_tick_spacing: assert property (tick_r |-> tick_cnt_r == 18'h00000
        && $past(tick_cnt_r) == 18'(MS_CYCLES_P - 1))
        else $error("millisecond tick out of step");

    // APB slave: one wait state, so every output comes from a flop
    assign acc = apb_in.psel && apb_in.penable && !rsp_r.pready;
    assign done = apb_in.psel && apb_in.penable && rsp_r.pready;
    assign cmd_wr = done && apb_in.pwrite && apb_in.paddr == OFS_CMD;
    assign mapped = apb_in.paddr == OFS_CTRL || apb_in.paddr == OFS_HOLD
        || apb_in.paddr == OFS_SEL || apb_in.paddr == OFS_STAT
        || apb_in.paddr == OFS_CMD;

    always_comb
    begin
        rd_data = 32'h00000000;
        case (apb_in.paddr)
            OFS_CTRL: rd_data = {23'h000000, code_ovr_r, code_ovr_en_r, st_ovr_r,
                st_ovr_en_r};
            OFS_HOLD: rd_data = {16'h0000, hold_r};
            OFS_SEL: rd_data = {22'h000000, rotary_selector_value == SEL_RSVD,
                rotary_selector_value != SEL_RSVD && rotary_selector_value != SEL_TEST
                && rotary_selector_value != SEL_CFG, rotary_selector_value};
            OFS_STAT: rd_data = {21'h000000, act_left_r != 10'h000, seen_r, mode_r,
                show_proto, ser_r, show_on, show_code};
            default: rd_data = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r.pready <= acc;
            rsp_r.pslverr <= acc && !mapped;
            rsp_r.prdata <= (acc && !apb_in.pwrite) ? rd_data : 32'h00000000;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            st_ovr_en_r <= 1'b0;
            st_ovr_r <= LOOK_OFF;
            code_ovr_en_r <= 1'b0;
            code_ovr_r <= 4'h0;
        end
        else if (done && apb_in.pwrite && apb_in.paddr == OFS_CTRL)
        begin
            st_ovr_en_r <= apb_in.pwdata[CTRL_ST_EN];
            st_ovr_r <= gsl_look_t'(apb_in.pwdata[CTRL_ST_LSB +: 3]);
            code_ovr_en_r <= apb_in.pwdata[CTRL_CODE_EN];
            code_ovr_r <= apb_in.pwdata[CTRL_CODE_LSB +: 4];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            hold_r <= WARN_HOLD_RST;
        else if (done && apb_in.pwrite && apb_in.paddr == OFS_HOLD)
            hold_r <= apb_in.pwdata[15:0];
    end

    // Rotary selectors are pins: two flops before use
    always_ff @(posedge clock_in)
    begin
        sel_meta_r <= {id_high_selector_in, id_low_selector_in};
        sel_sync_r <= sel_meta_r;
    end

    // Wait lets the synchroniser fill before the power-on capture
    always_ff @(posedge clock_in)
    begin
        if (reset_in || cmd_wr)
            cap_wait_r <= 2'h3;
        else if (cap_wait_r != 2'h0)
            cap_wait_r <= cap_wait_r - 2'h1;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            rotary_selector_value <= 8'h00;
        else if (cap_wait_r == 2'h1)
            rotary_selector_value <= sel_sync_r;
    end

    chk_cmd_capture: assert property (cmd_wr ##1 !cmd_wr [*3] |=>
        rotary_selector_value == $past(sel_sync_r))
        else $error("selector not captured after command");

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            mode_r <= MODE_RUN;
        else if (rotary_selector_value == SEL_CFG)
            mode_r <= MODE_CFG;
        else if (rotary_selector_value == SEL_TEST)
            mode_r <= MODE_TEST;
        else
            mode_r <= MODE_RUN;
    end

    chk_mode_select: assert property (rotary_selector_value == SEL_CFG
        [*2] |-> mode_r == MODE_CFG)
        else $error("config selector did not enter config mode");

    // Error intake; a hardware report wins over a script raise in one cycle
    always_comb
    begin
        if (err_in.valid)
            src = err_in;
        else
            src = '{valid: cmd_wr && apb_in.pwdata[CMD_RAISE],
                proto: apb_in.pwdata[CMD_PROTO], code: apb_in.pwdata[3:0]};
        new_ser = src.valid && !src.proto && src.code != 4'h0
            && src.code <= SERIOUS_MAX;
        new_warn = src.valid && src.code != 4'h0 && !new_ser;
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            ser_r <= 1'b0;
            ser_code_r <= 4'h0;
        end
        else if (new_ser && !ser_r)
        begin
            ser_r <= 1'b1;
            ser_code_r <= src.code;
        end
    end

    chk_serious_latch: assert property (ser_r |=> ser_r && $stable(ser_code_r))
        else $error("serious error released");

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            warn_code_r <= 4'h0;
            warn_proto_r <= 1'b0;
            warn_left_r <= 16'h0000;
        end
        else if (new_warn)
        begin
            warn_code_r <= src.code;
            warn_proto_r <= src.proto;
            warn_left_r <= src.proto ? hold_r : 16'(WARN_SYS_MS);
        end
        else if (tick_r && warn_left_r != 16'h0000)
        begin
            warn_left_r <= warn_left_r - 16'h0001;
        end
    end

    chk_warn_reload: assert property (new_warn && !src.proto |=>
        warn_left_r == 16'(WARN_SYS_MS) && warn_code_r == $past(src.code))
        else $error("warning not reloaded");

    chk_warn_expire: assert property (warn_left_r == 16'h0001 && tick_r
        && !new_warn |=> warn_left_r == 16'h0000 && (!show_on || ser_r))
        else $error("warning did not expire");

    assign show_on = ser_r || warn_left_r != 16'h0000;
    assign show_code = ser_r ? ser_code_r : warn_code_r;
    assign show_proto = !ser_r && warn_proto_r;

    chk_serious_first: assert property (ser_r && new_warn |=>
        show_code == ser_code_r)
        else $error("warning displaced serious error");

    // Serial exchange activity window
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            seen_r <= 1'b0;
            act_left_r <= 10'h000;
        end
        else if (serial_exchange_in)
        begin
            seen_r <= 1'b1;
            act_left_r <= 10'(ACT_WINDOW_MS);
        end
        else if (tick_r && act_left_r != 10'h000)
        begin
            act_left_r <= act_left_r - 10'h001;
        end
    end

    // Pattern selection for each lamp
    always_comb
    begin
        if (fb_status_in.watchdog_timeout)
            pat_nxt[LMP_FAULT] = PAT_DOUBLE;
        else if (fb_status_in.app_layer_state_word[AL_CHG_BIT])
            pat_nxt[LMP_FAULT] = PAT_SINGLE;
        else if (fb_status_in.config_error)
            pat_nxt[LMP_FAULT] = PAT_BLINK;
        else
            pat_nxt[LMP_FAULT] = PAT_OFF;
        case (fb_status_in.fb_state)
            FB_PREOP: pat_nxt[LMP_RUN] = PAT_BLINK;
            FB_SAFEOP: pat_nxt[LMP_RUN] = PAT_SINGLE;
            FB_OP: pat_nxt[LMP_RUN] = PAT_ON;
            default: pat_nxt[LMP_RUN] = PAT_OFF;
        endcase
        if (st_ovr_en_r)
            look_nxt = st_ovr_r;
        else if (mode_r != MODE_RUN)
            look_nxt = LOOK_RED_FLASH;
        else if (show_on)
            look_nxt = LOOK_RED;
        else if (act_left_r != 10'h000)
            look_nxt = LOOK_GREEN;
        else if (seen_r)
            look_nxt = LOOK_GREEN_FLASH;
        else
            look_nxt = LOOK_ALT;
        case (look_nxt)
            LOOK_GREEN, LOOK_RED: pat_nxt[LMP_STATE] = PAT_ON;
            LOOK_GREEN_FLASH, LOOK_ALT, LOOK_RED_FLASH: pat_nxt[LMP_STATE] = PAT_BLINK;
            default: pat_nxt[LMP_STATE] = PAT_OFF;
        endcase
        if (mode_r == MODE_CFG)
        begin
            // Internal content only; users must not read meaning into it
            pat_nxt[LMP_CODE] = PAT_ON;
            code_val_nxt = rotary_selector_value[3:0];
        end
        else if (look_nxt == LOOK_RED && !st_ovr_en_r)
        begin
            pat_nxt[LMP_CODE] = show_proto ? PAT_SLOW : PAT_FAST;
            code_val_nxt = show_code;
        end
        else if (code_ovr_en_r)
        begin
            pat_nxt[LMP_CODE] = PAT_ON;
            code_val_nxt = code_ovr_r;
        end
        else
        begin
            pat_nxt[LMP_CODE] = PAT_OFF;
            code_val_nxt = 4'h0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            look_r <= LOOK_OFF;
            code_val_r <= 4'h0;
        end
        else
        begin
            look_r <= look_nxt;
            code_val_r <= code_val_nxt;
        end
    end

    // One sequencer per lamp, restarting at the first lit phase
    for (genvar i = 0; i < 4; i++)
    begin : g_seq
        always_ff @(posedge clock_in)
        begin
            if (reset_in)
            begin
                pat_r[i] <= PAT_OFF;
                pos_r[i] <= 11'h000;
            end
            else if (pat_nxt[i] != pat_r[i])
            begin
                pat_r[i] <= pat_nxt[i];
                pos_r[i] <= 11'h000;
            end
            else if (tick_r)
            begin
                pos_r[i] <= (pos_r[i] + 11'h001 >= pat_period(pat_r[i])) ? 11'h000
                    : pos_r[i] + 11'h001;
            end
        end
        assign lit[i] = pat_lit(pat_r[i], pos_r[i]);
    end

    chk_seq_restart: assert property (pat_nxt[LMP_RUN] != pat_r[LMP_RUN] |=>
        pos_r[LMP_RUN] == 11'h000 && pat_r[LMP_RUN] == $past(pat_nxt[LMP_RUN]))
        else $error("sequencer did not restart");

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            lamps_r <= '0;
        end
        else
        begin
            lamps_r.fault_lamp <= lit[LMP_FAULT];
            lamps_r.run_lamp <= lit[LMP_RUN];
            lamps_r.state_green <= (look_r == LOOK_ALT) ? lit[LMP_STATE]
                : lit[LMP_STATE] && (look_r == LOOK_GREEN || look_r == LOOK_GREEN_FLASH);
            lamps_r.state_red <= (look_r == LOOK_ALT) ? !lit[LMP_STATE]
                : lit[LMP_STATE] && (look_r == LOOK_RED || look_r == LOOK_RED_FLASH);
            {lamps_r.code_lamp_weight_eight, lamps_r.code_lamp_weight_four,
                lamps_r.code_lamp_weight_two, lamps_r.code_lamp_weight_one}
                <= lit[LMP_CODE] ? code_val_r : 4'h0;
        end
    end

    assign lamps_out = lamps_r;
    assign apb_out = rsp_r;

    chk_fault_dark: assert property (!fb_status_in.watchdog_timeout
        && !fb_status_in.config_error
        && !fb_status_in.app_layer_state_word[AL_CHG_BIT] [*2] |=> !lamps_out.fault_lamp)
        else $error("fault lamp lit while healthy");

    chk_run_lit: assert property (fb_status_in.fb_state == FB_OP [*2]
        |=> lamps_out.run_lamp)
        else $error("run lamp dark in operational state");

    chk_blink_dark: assert property (pat_r[LMP_RUN] == PAT_BLINK
        && pos_r[LMP_RUN] >= 11'(SHORT_MS) |=> !lamps_out.run_lamp)
        else $error("blink dark phase wrong");

    chk_single_dark: assert property (pat_r[LMP_FAULT] == PAT_SINGLE
        && pos_r[LMP_FAULT] >= 11'(SHORT_MS) |=> !lamps_out.fault_lamp)
        else $error("single flash dark phase wrong");

    chk_double_lit: assert property (pat_r[LMP_FAULT] == PAT_DOUBLE
        && pos_r[LMP_FAULT] >= 11'(2 * SHORT_MS) && pos_r[LMP_FAULT] < 11'(3 * SHORT_MS)
        |=> lamps_out.fault_lamp)
        else $error("double flash second flash missing");

    chk_code_rate: assert property (pat_r[LMP_CODE] == PAT_FAST
        && pos_r[LMP_CODE] >= 11'(FAST_HALF_MS) |=> !lamps_out.code_lamp_weight_one
        && !lamps_out.code_lamp_weight_eight)
        else $error("system code flash rate wrong");

    chk_state_red: assert property (look_r == LOOK_RED && pat_r[LMP_STATE] == PAT_ON
        |=> lamps_out.state_red && !lamps_out.state_green)
        else $error("state lamp not red on error");

endmodule : gsl_lamp_ctrl

// ==== tb/gsl_panel.sv ====
// Front panel model: rotary selector digits facing the lamp controller
`timescale 1ns/10ps
module gsl_panel (
    input wire logic [7:0] setting_in,
    input gsl_pkg::gsl_lamps_t lamps_in,
    output logic [3:0] id_high_selector_out,
    output logic [3:0] id_low_selector_out
);
    import gsl_pkg::*;
    // Switches are mechanical, so the digits follow the setting at any time
    assign id_high_selector_out = setting_in[7:4];
    assign id_low_selector_out = setting_in[3:0];
endmodule : gsl_panel

// ==== tb/tb_gateway_status_led_indicator.sv ====
// Self-checking bench for the status lamp controller
`timescale 1ns/10ps
module tb_gateway_status_led_indicator;
    import gsl_pkg::*;
    logic clock_in = 0;
    logic reset_in = 1;
    gsl_apb_req_t req = '0;
    gsl_apb_rsp_t rsp;
    gsl_fb_status_t fb = '0;
    logic xchg = 0;
    gsl_err_t err = '0;
    logic [7:0] sel = 8'hff;
    logic [3:0] hi;
    logic [3:0] lo;
    gsl_lamps_t lamps_out;
    wire logic [7:0] lamps = lamps_out;
    int bad_count = 0;
    int checks_done = 0;
    logic [31:0] rd;
    logic er;
    always #2 clock_in = ~clock_in;
    gsl_lamp_ctrl #(.MS_CYCLES_P(10)) u_dut (.clock_in(clock_in), .reset_in(reset_in),
        .apb_in(req), .apb_out(rsp), .fb_status_in(fb), .serial_exchange_in(xchg),
        .err_in(err), .id_high_selector_in(hi), .id_low_selector_in(lo),
        .lamps_out(lamps_out));
    gsl_panel u_panel (.setting_in(sel), .lamps_in(lamps_out),
        .id_high_selector_out(hi), .id_low_selector_out(lo));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_in);
        req.penable <= 1'b1;
        // Only the watchdog ends a wait for pready
        do
        begin
            @(posedge clock_in);
        end
        while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb
    // Times a full dark then lit phase, in ms of 10 cycles
    // Fresh skips the first lit phase: a restart cuts it by up to one tick
    task automatic meas(input int b, input logic fresh, input int lit_ms, input int dark_ms);
        int n;
        int m;
        n = 0;
        m = 0;
        while (fresh && lamps[b] !== 1'b1)
        begin
            @(posedge clock_in);
        end
        while (lamps[b] === 1'b1)
        begin
            @(posedge clock_in);
        end
        while (lamps[b] !== 1'b1)
        begin
            @(posedge clock_in);
            m++;
        end
        while (lamps[b] === 1'b1)
        begin
            @(posedge clock_in);
            n++;
        end
        check(32'((n + 5) / 10), 32'(lit_ms));
        check(32'((m + 5) / 10), 32'(dark_ms));
    endtask : meas
    task automatic errp(input logic p, input logic [3:0] c);
        @(posedge clock_in);
        err <= '{1'b1, p, c};
        @(posedge clock_in);
        err.valid <= 1'b0;
    endtask : errp
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #380000;
        bad_count++;
        report_and_stop();
    end
    initial
    begin
        repeat (6) @(posedge clock_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        apb(1'b0, OFS_HOLD, '0);
        check(rd, 32'h0000ea60);
        apb(1'b0, 8'h14, '0);
        check({31'h0, er}, 32'h1);
        apb(1'b0, OFS_SEL, '0);
        check(rd, 32'h000000ff);
        apb(1'b0, OFS_STAT, '0);
        check(32'(rd[8:7]), 32'h2);
        sel <= 8'hdd;
        apb(1'b1, OFS_CMD, '0);
        repeat (3) @(posedge clock_in);
        apb(1'b0, OFS_SEL, '0);
        check(rd, 32'h000002dd);
        sel <= 8'h5a;
        apb(1'b1, OFS_CMD, '0);
        repeat (3) @(posedge clock_in);
        apb(1'b0, OFS_SEL, '0);
        check(rd, 32'h0000015a);
        $display("Registers and selector done");
        fb.fb_state <= FB_PREOP;
        meas(LMP_RUN + 5, 1'b1, 200, 200);
        fb.fb_state <= FB_SAFEOP;
        meas(6, 1'b1, 200, 1000);
        fb.fb_state <= FB_OP;
        repeat (5) @(posedge clock_in);
        check({31'h0, lamps[6]}, 32'h1);
        fb.watchdog_timeout <= 1'b1;
        meas(7, 1'b1, 200, 200);
        meas(7, 1'b0, 200, 1000);
        fb.watchdog_timeout <= 1'b0;
        fb.app_layer_state_word <= 16'h0010;
        meas(7, 1'b1, 200, 1000);
        fb.app_layer_state_word <= 16'h0000;
        fb.config_error <= 1'b1;
        meas(7, 1'b1, 200, 200);
        fb.config_error <= 1'b0;
        repeat (5) @(posedge clock_in);
        check({31'h0, lamps[7]}, 32'h0);
        $display("Fault and run lamps done");
        @(posedge clock_in);
        xchg <= 1'b1;
        @(posedge clock_in);
        xchg <= 1'b0;
        repeat (5) @(posedge clock_in);
        check(32'(lamps[5:4]), 32'h2);
        apb(1'b1, OFS_CTRL, 32'h00000009);
        repeat (3) @(posedge clock_in);
        check(32'(lamps[5:4]), 32'h1);
        apb(1'b1, OFS_CTRL, '0);
        $display("State lamp done");
        // Hold outlasts the measured phases, then runs out before the read
        apb(1'b1, OFS_HOLD, 32'h00000640);
        apb(1'b1, OFS_CMD, 32'h00000305);
        meas(0, 1'b1, 500, 500);
        repeat (3500) @(posedge clock_in);
        apb(1'b0, OFS_STAT, '0);
        check(32'(rd[4]), 32'h0);
        errp(1'b0, 4'h9);
        meas(0, 1'b1, 250, 250);
        check(32'(lamps[4]), 32'h1);
        apb(1'b0, OFS_STAT, '0);
        check(32'(rd[6:0]), 32'h19);
        errp(1'b0, 4'h2);
        apb(1'b0, OFS_STAT, '0);
        check(32'(rd[6:0]), 32'h32);
        errp(1'b0, 4'h9);
        apb(1'b0, OFS_STAT, '0);
        check(32'(rd[6:0]), 32'h32);
        $display("Error display done");
        report_and_stop();
    end
endmodule : tb_gateway_status_led_indicator
